// File: logic/tpf_config.sv
/*
  Configuration registers for fuse-map load, test patterns and frame clock.
  Sample streams come from the converter core and leave for the bit mapper.
  Assumes a synchronous byte-wide register write/read port driven by the
  serial-interface decoder on the sampling clock.
*/
`timescale 1ns/1ps
module tpf_config (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [tpf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tpf_pkg::DATA_W-1:0] reg_wdata,
  output logic [tpf_pkg::DATA_W-1:0] reg_rdata_q,
  input wire logic sample_valid,
  input wire logic [tpf_pkg::SAMPLE_W-1:0] chan_a_sample,
  input wire logic [tpf_pkg::SAMPLE_W-1:0] chan_b_sample,
  output logic [tpf_pkg::SAMPLE_W-1:0] chan_a_to_mapper_q,
  output logic [tpf_pkg::SAMPLE_W-1:0] chan_b_to_mapper_q,
  output logic fuse_map_load_pulse_q,
  output logic frame_clock_source_q,
  output logic frame_clock_divide_q,
  output logic frame_clock_stretch_q
);
  import tpf_pkg::*;

  logic fuse_map_load_q;
  logic [7:0] pattern_word_low_q;
  logic [7:0] pattern_word_mid_q;
  logic [7:0] pattern_select_and_word_high_q;
  logic [7:0] frame_clock_config_q;
  logic fuse_fall;
  logic wr_fuse;
  logic wr_low;
  logic wr_mid;
  logic wr_high;
  logic wr_frame_clock;
  logic [SAMPLE_W-1:0] user_pattern_word;
  logic [2:0] chan_sel [NUM_CHAN];
  logic [SAMPLE_W-1:0] chan_in [NUM_CHAN];
  logic [SAMPLE_W-1:0] chan_out [NUM_CHAN];

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  // Writes to addresses outside the map raise none of these strobes.
  assign wr_fuse = reg_write && hit(reg_addr, FUSE_MAP_LOAD_CTRL_ADDR);
  assign wr_low = reg_write && hit(reg_addr, PATTERN_WORD_LOW_ADDR);
  assign wr_mid = reg_write && hit(reg_addr, PATTERN_WORD_MID_ADDR);
  assign wr_high = reg_write && hit(reg_addr, PATTERN_SELECT_AND_WORD_HIGH_ADDR);
  assign wr_frame_clock = reg_write && hit(reg_addr, FRAME_CLOCK_CONFIG_ADDR);

  // ---------------------------------------------------------------
  // Fuse-map load
  // ---------------------------------------------------------------
  // The load takes effect when the bit goes back from one to zero.
  assign fuse_fall = fuse_map_load_q && wr_fuse && !reg_wdata[FUSE_LOAD_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fuse_map_load_q <= 1'b0;
    end else if (wr_fuse) begin
      fuse_map_load_q <= reg_wdata[FUSE_LOAD_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fuse_map_load_pulse_q <= 1'b0;
    end else begin
      fuse_map_load_pulse_q <= fuse_fall;
    end
  end

  // ---------------------------------------------------------------
  // Pattern and frame-clock registers
  // ---------------------------------------------------------------
  // The fuse load wipes earlier writes, so it beats a same-cycle write.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pattern_word_low_q <= REG_RESET;
    end else if (fuse_fall) begin
      pattern_word_low_q <= REG_RESET;
    end else if (wr_low) begin
      pattern_word_low_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pattern_word_mid_q <= REG_RESET;
    end else if (fuse_fall) begin
      pattern_word_mid_q <= REG_RESET;
    end else if (wr_mid) begin
      pattern_word_mid_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pattern_select_and_word_high_q <= REG_RESET;
    end else if (fuse_fall) begin
      pattern_select_and_word_high_q <= REG_RESET;
    end else if (wr_high) begin
      pattern_select_and_word_high_q <= reg_wdata;
    end
  end

  // Reserved bits of the frame-clock register are never stored.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_clock_config_q <= REG_RESET;
    end else if (fuse_fall) begin
      frame_clock_config_q <= REG_RESET;
    end else if (wr_frame_clock) begin
      frame_clock_config_q <= reg_wdata & FRAME_CLOCK_CONFIG_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  // Unmapped addresses and the unused load-register bits read as zero.
  function automatic logic [DATA_W-1:0] read_back(input logic [ADDR_W-1:0] a);
    if (hit(a, FUSE_MAP_LOAD_CTRL_ADDR)) begin
      read_back = {DATA_W{fuse_map_load_q}} & FUSE_MAP_LOAD_CTRL_MASK;
    end else if (hit(a, PATTERN_WORD_LOW_ADDR)) begin
      read_back = pattern_word_low_q;
    end else if (hit(a, PATTERN_WORD_MID_ADDR)) begin
      read_back = pattern_word_mid_q;
    end else if (hit(a, PATTERN_SELECT_AND_WORD_HIGH_ADDR)) begin
      read_back = pattern_select_and_word_high_q;
    end else if (hit(a, FRAME_CLOCK_CONFIG_ADDR)) begin
      read_back = frame_clock_config_q;
    end else begin
      read_back = REG_RESET;
    end
  endfunction

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= REG_RESET;
    end else if (reg_read) begin
      reg_rdata_q <= read_back(reg_addr);
    end
  end

  // ---------------------------------------------------------------
  // Frame-clock controls
  // ---------------------------------------------------------------
  // Bypass and real decimation share one setting; the host picks the code.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_clock_source_q <= 1'b0;
    end else begin
      frame_clock_source_q <= frame_clock_config_q[FRAME_CLOCK_SOURCE_BIT];
    end
  end

  // Divide and stretch are passed on as written; legal mode pairs are the host's duty.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_clock_divide_q <= 1'b0;
    end else begin
      frame_clock_divide_q <= frame_clock_config_q[FRAME_CLOCK_DIVIDE_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_clock_stretch_q <= 1'b0;
    end else begin
      frame_clock_stretch_q <= frame_clock_config_q[FRAME_CLOCK_STRETCH_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Test-pattern injection ahead of the bit mapper
  // ---------------------------------------------------------------
  // Both channels share one user word; only their selects differ.
  assign user_pattern_word = {pattern_select_and_word_high_q[WORD_HIGH_HI:WORD_HIGH_LO],
                              pattern_word_mid_q, pattern_word_low_q};
  assign chan_sel[0] = pattern_select_and_word_high_q[SEL_A_HI:SEL_A_LO];
  assign chan_sel[1] = pattern_select_and_word_high_q[SEL_B_HI:SEL_B_LO];
  assign chan_in[0] = chan_a_sample;
  assign chan_in[1] = chan_b_sample;

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : gen_chan
      tpf_pattern_gen u_gen (
        .clk(clk),
        .reset_n(reset_n),
        .select(chan_sel[g]),
        .user_pattern_word(user_pattern_word),
        .sample_valid(sample_valid),
        .sample_in(chan_in[g]),
        .sample_out_q(chan_out[g])
      );
    end
  endgenerate

  assign chan_a_to_mapper_q = chan_out[0];
  assign chan_b_to_mapper_q = chan_out[1];
endmodule

// File: logic/tpf_pkg.sv
/*
  Package for the test-pattern and frame-clock configuration block.
  Holds register offsets, field positions, pattern codes and reset values.
  Assumes a byte-wide register port with 8-bit addresses.
*/
package tpf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 18;

  localparam logic [7:0] FUSE_MAP_LOAD_CTRL_ADDR = 8'h13;
  localparam logic [7:0] PATTERN_WORD_LOW_ADDR = 8'h14;
  localparam logic [7:0] PATTERN_WORD_MID_ADDR = 8'h15;
  localparam logic [7:0] PATTERN_SELECT_AND_WORD_HIGH_ADDR = 8'h16;
  localparam logic [7:0] FRAME_CLOCK_CONFIG_ADDR = 8'h19;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [17:0] SAMPLE_ZERO = 18'h00000;

  localparam int FUSE_LOAD_BIT = 0;
  localparam int SEL_B_HI = 7;
  localparam int SEL_B_LO = 5;
  localparam int SEL_A_HI = 4;
  localparam int SEL_A_LO = 2;
  localparam int WORD_HIGH_HI = 1;
  localparam int WORD_HIGH_LO = 0;
  localparam int FRAME_CLOCK_SOURCE_BIT = 7;
  localparam int FRAME_CLOCK_DIVIDE_BIT = 4;
  localparam int FRAME_CLOCK_STRETCH_BIT = 0;

  localparam logic [7:0] FUSE_MAP_LOAD_CTRL_MASK = 8'h01;
  localparam logic [7:0] FRAME_CLOCK_CONFIG_MASK = 8'h91;

  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_RAMP = 3'h2;
  localparam logic [2:0] PAT_CONST = 3'h3;

  localparam int NUM_CHAN = 2;
endpackage

// File: logic/tpf_pattern_gen.sv
/*
  One channel of the test-pattern source: normal data, ramp or constant.
  Assumes samples arrive as a valid-qualified stream on the sampling clock.
*/
`timescale 1ns/1ps
module tpf_pattern_gen (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] select,
  input wire logic [tpf_pkg::SAMPLE_W-1:0] user_pattern_word,
  input wire logic sample_valid,
  input wire logic [tpf_pkg::SAMPLE_W-1:0] sample_in,
  output logic [tpf_pkg::SAMPLE_W-1:0] sample_out_q
);
  import tpf_pkg::*;

  // ---------------------------------------------------------------
  // Output source selection
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_out_q <= SAMPLE_ZERO;
    end else if (sample_valid) begin
      case (select)
        PAT_NORMAL: sample_out_q <= sample_in;
        PAT_RAMP: sample_out_q <= sample_out_q + user_pattern_word;
        PAT_CONST: sample_out_q <= user_pattern_word;
        // Unused codes hold the output at zero.
        default: sample_out_q <= SAMPLE_ZERO;
      endcase
    end
  end
endmodule

// File: sim/tpf_config_chk.sv
/* Port-level checker for tpf_config.
   Assumes attachment by the bind at the foot of this file. */
`timescale 1ns/1ps
module tpf_config_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [tpf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tpf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [tpf_pkg::DATA_W-1:0] reg_rdata_q,
  input wire logic sample_valid,
  input wire logic [tpf_pkg::SAMPLE_W-1:0] chan_a_to_mapper_q,
  input wire logic [tpf_pkg::SAMPLE_W-1:0] chan_b_to_mapper_q,
  input wire logic fuse_map_load_pulse_q,
  input wire logic frame_clock_source_q,
  input wire logic frame_clock_divide_q,
  input wire logic frame_clock_stretch_q
);
  import tpf_pkg::*;
  logic fuse_bit_q;
  wire logic fuse_wr = reg_write && reg_addr == FUSE_MAP_LOAD_CTRL_ADDR;
  wire logic fall_wr = fuse_wr && !reg_wdata[0] && fuse_bit_q;
  wire logic [2:0] frame_clock_bits = {reg_wdata[7], reg_wdata[4], reg_wdata[0]};
  wire logic [2:0] frame_clock_out = {frame_clock_source_q, frame_clock_divide_q, frame_clock_stretch_q};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Shadow of the load bit, so that only a one-to-zero write counts as a load.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fuse_bit_q <= 1'b0;
    end else if (fuse_wr) begin
      fuse_bit_q <= reg_wdata[0];
    end
  end
  chk_fuse_fires: assert property (fall_wr |-> ##[1:2] fuse_map_load_pulse_q)
    else $error("load pulse missing");
  chk_fuse_cause: assert property (fuse_map_load_pulse_q |-> $past(fall_wr) || $past(fall_wr, 2))
    else $error("load pulse without cause");
  chk_pulse_single: assert property (fuse_map_load_pulse_q |=> !fuse_map_load_pulse_q)
    else $error("load pulse too long");
  chk_frame_clock_follow: assert property (reg_write && reg_addr == FRAME_CLOCK_CONFIG_ADDR
    |-> ##2 frame_clock_out == $past(frame_clock_bits, 2))
    else $error("frame clock bits wrong");
  chk_chan_a_hold: assert property (!sample_valid |=> $stable(chan_a_to_mapper_q))
    else $error("channel a moved without sample");
  chk_chan_b_hold: assert property (!sample_valid |=> $stable(chan_b_to_mapper_q))
    else $error("channel b moved without sample");
  chk_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata_q))
    else $error("read data moved");
  chk_unmapped_zero: assert property (reg_read && !(reg_addr inside {8'h13, 8'h14, 8'h15,
    8'h16, 8'h19}) |=> reg_rdata_q == REG_RESET)
    else $error("unmapped read not zero");
  chk_load_clears: assert property (fuse_map_load_pulse_q |=> frame_clock_out == 3'h0)
    else $error("frame clock bits kept after load");
  cover property (fuse_map_load_pulse_q);
  cover property (frame_clock_divide_q);
  cover property (frame_clock_source_q);
  cover property (sample_valid [*2]);
endmodule
bind tpf_config tpf_config_chk u_tpf_config_chk (.clk, .reset_n, .reg_write, .reg_read,
  .reg_addr, .reg_wdata, .reg_rdata_q, .sample_valid, .chan_a_to_mapper_q,
  .chan_b_to_mapper_q, .fuse_map_load_pulse_q, .frame_clock_source_q,
  .frame_clock_divide_q, .frame_clock_stretch_q);

// File: sim/tpf_host.sv
/* Host register master for tpf_config.
   Assumes the bench calls xfer; requests move on the falling edge. */
`timescale 1ns/1ps
module tpf_host (
  input wire logic clk,
  input wire logic [tpf_pkg::DATA_W-1:0] reg_rdata_q,
  output logic reg_write,
  output logic reg_read,
  output logic [tpf_pkg::ADDR_W-1:0] reg_addr,
  output logic [tpf_pkg::DATA_W-1:0] reg_wdata
);
  import tpf_pkg::*;
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released address and data lines carry inverted values so nothing relies on a stale address or data.
  task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge clk);
    reg_write = is_wr;
    reg_read = !is_wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    q = reg_rdata_q;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// File: sim/test_pattern_frame_clock_cfg_test.sv
/* Self-checking bench for tpf_config driven by the tpf_host model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module test_pattern_frame_clock_cfg_test;
  import tpf_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sample_valid = 1'b0;
  logic reg_write, reg_read, src, div, str, load_pulse;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, q;
  logic [17:0] chan_a_sample = 18'h15555;
  logic [17:0] chan_b_sample = 18'h2aaaa;
  logic [17:0] a_out, b_out;
  logic [7:0] addrs [6] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h19, 8'h17};
  logic [7:0] fcfg [4] = '{8'h10, 8'h00, 8'h80, 8'h01};
  int miscompares = 0;
  int checks_done = 0;
  tpf_config u_tpf_config (.clk, .reset_n, .reg_write, .reg_read, .reg_addr, .reg_wdata,
    .reg_rdata_q, .sample_valid, .chan_a_sample, .chan_b_sample, .chan_a_to_mapper_q(a_out),
    .chan_b_to_mapper_q(b_out), .fuse_map_load_pulse_q(load_pulse), .frame_clock_source_q(src),
    .frame_clock_divide_q(div), .frame_clock_stretch_q(str));
  tpf_host u_tpf_host (.clk, .reg_rdata_q, .reg_write, .reg_read, .reg_addr, .reg_wdata);
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic cmp(input string what, input logic [17:0] exp, input logic [17:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_tpf_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    u_tpf_host.xfer(1'b0, a, 8'h00, q);
    cmp($sformatf("reg %h", a), {10'h000, exp}, {10'h000, q});
  endtask
  task automatic run(input int n);
    sample_valid = 1'b1;
    repeat (n) @(negedge clk);
    sample_valid = 1'b0;
  endtask
  task automatic end_sim;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    wr(8'h13, 8'h01);
    wr(8'h13, 8'h00);
    cmp("load_pulse", 18'h00001, {17'h00000, load_pulse});
    wr(8'h14, 8'h01);
    wr(8'h16, 8'h0e);
    rd(8'h16, 8'h0e);
    run(2);
    cmp("chan_a", 18'h20001, a_out);
    cmp("chan_b", chan_b_sample, b_out);
    wr(8'h16, 8'h48);
    run(4);
    cmp("chan_a", 18'h20005, a_out);
    cmp("chan_b", chan_b_sample + 18'h4, b_out);
    wr(8'h16, 8'h60);
    run(1);
    cmp("chan_a", chan_a_sample, a_out);
    cmp("chan_b", 18'h00001, b_out);
    wr(8'h15, 8'h80);
    run(1);
    cmp("chan_b", 18'h08001, b_out);
    wr(8'h16, 8'h24);
    run(1);
    cmp("chan_a", SAMPLE_ZERO, a_out);
    cmp("chan_b", SAMPLE_ZERO, b_out);
    foreach (fcfg[i]) begin
      wr(8'h19, fcfg[i]);
      @(negedge clk);
      cmp("frame_clock", {15'h0, fcfg[i][7], fcfg[i][4], fcfg[i][0]}, {15'h0, src, div, str});
      rd(8'h19, fcfg[i]);
    end
    wr(8'h13, 8'h01);
    wr(8'h13, 8'h00);
    cmp("load_pulse", 18'h00001, {17'h00000, load_pulse});
    @(negedge clk);
    cmp("load_pulse", SAMPLE_ZERO, {17'h00000, load_pulse});
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    cmp("frame_clock", 18'h0, {15'h0, src, div, str});
    wr(8'h19, 8'h80);
    wr(8'h16, 8'h0e);
    run(1);
    cmp("chan_a", 18'h20000, a_out);
    cmp("frame_clock", 18'h00004, {15'h0, src, div, str});
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    cmp("frame_clock", 18'h0, {15'h0, src, div, str});
    cmp("chan_a", SAMPLE_ZERO, a_out);
    end_sim;
  end
endmodule
